//--- hdl/svd_pkg.sv
// package: register map, field layout, reset values and timing of the supply threshold detector
package svd_pkg;
  // =========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL     = 8'h04;
  localparam logic [7:0] ADDR_FLAGS      = 8'h08;
  localparam logic [7:0] ADDR_ENABLES    = 8'h0C;
  localparam logic [7:0] ADDR_PRIORITIES = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] ADDR_SLEEP      = 8'h20;
  // =========================================================
  // field positions
  localparam int POS_DIRECTION   = 7;
  localparam int POS_REF_STABLE  = 5;
  localparam int POS_ENABLE      = 4;
  localparam int POS_DET_BIT     = 2;
  localparam int POS_GLOBAL_IRQ  = 7;
  localparam int POS_PERIPH_IRQ  = 6;
  // =========================================================
  // masks of implemented writable bits
  localparam logic [7:0] MASK_CONTROL_WR = 8'h9F;
  localparam logic [7:0] MASK_GLOBAL_WR  = 8'hC0;
  localparam logic [7:0] MASK_DET_BIT    = 8'h04;
  // =========================================================
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h05;
  localparam logic [7:0] RST_GLOBAL  = 8'h00;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_PRIOS   = 8'h04;
  // =========================================================
  // trip select and timing
  localparam logic [3:0] TRIP_EXTERNAL = 4'hF;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STARTUP_TIME_NS = 20000;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // =========================================================
  // analogue front end steering and status
  typedef struct packed {
    logic       comp_enable;
    logic       use_external;
    logic [3:0] tap_select;
    logic       direction;
  } analog_ctrl_t;
  typedef struct packed {
    logic tripped;
    logic ref_ready;
  } analog_stat_t;
endpackage

//--- hdl/svd_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module svd_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s2_r[i];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= async_in; // [RQ18]
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end
  assign sync_out = out_r;
endmodule
`default_nettype wire

//--- hdl/svd_startup.sv
// reference start-up interval counter
`timescale 1ns/10ps
`default_nettype none
module svd_startup #(
  parameter int CYCLES = 2000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic ref_ready,
  output logic      stable
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          stable_r, stable_nxt;
  always_comb begin
    cnt_nxt    = cnt_r;
    stable_nxt = stable_r;
    if (!enable) begin
      cnt_nxt    = '0;
      stable_nxt = 1'b0;
    end else if (cnt_r != LAST) begin
      cnt_nxt = cnt_r + CW'(1); // [RQ9]
    end else if (ref_ready) begin
      stable_nxt = 1'b1; // [RQ17]
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= '0;
      stable_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      stable_r <= stable_nxt;
    end
  end
  assign stable = stable_r;
endmodule
`default_nettype wire

//--- hdl/supply_threshold_detector.sv
// supply threshold detector control, flags and AXI4-Lite register slave
//
// How it works
// (RQ1) four-bit trip select in control bits 3:0 picks one of fifteen thresholds or the external input
// (RQ2) trip select all ones steers the external detect input to the comparator
// (RQ3) comparator trip at selected point in set direction sets the detector flag
// (RQ4) direction bit one detects rising supply, zero detects falling supply
// (RQ5) software disables, writes trip select, direction, then re-enables
// (RQ6) software clears stale detector flag after enabling
// (RQ7) software sets detector enable and global enable bits for interrupts
// (RQ8) no detector interrupt before the reference stable bit is set
// (RQ9) after enable, flag setting blocked for a fixed reference start-up time
// (RQ10) software enables the detector only briefly to save static current
// (RQ11) enabled detector keeps running in sleep; a trip sets flag and wakes core
// (RQ12) wake vectors to interrupt only with global enable, else resumes after sleep
// (RQ13) any reset restores all registers, leaving the detector disabled
// (RQ14) unimplemented bits read zero and ignore writes
// (RQ15) direction one: event at or above trip; zero: at or below
// (RQ16) code 1110 is highest threshold, 0000 lowest, ordered by code
// (RQ17) reference stable is read-only, clears on reset, set by hardware only
// (RQ18) comparator output and reference ready are synchronised before use
`timescale 1ns/10ps
`default_nettype none
module supply_threshold_detector #(
  parameter int STARTUP_CYCLES = svd_pkg::STARTUP_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire svd_pkg::analog_stat_t analog_stat,
  output svd_pkg::analog_ctrl_t      analog_ctrl,
  input  wire logic                  core_sleeping,
  output logic                       wake_r,
  output logic                       vector_to_isr_r,
  output logic                       irq_r
);
  import svd_pkg::*;
  // =========================================================
  // state
  logic [7:0]   ctrl_r, ctrl_nxt, glob_r, glob_nxt, flags_r, flags_nxt;
  logic [7:0]   ens_r, ens_nxt, prio_r, prio_nxt;
  logic         sts_r, sts_nxt, ien_r, ien_nxt;
  analog_ctrl_t actl_r, actl_nxt;
  logic         wake_nxt, vec_nxt, irq_nxt;
  logic         aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]   awaddr_r, awaddr_nxt;
  logic [31:0]  wdata_r, wdata_nxt;
  logic         bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]   bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  logic [1:0]   synced;
  logic         trip_s, ref_s, stable, trip_d_r, trip_edge, event_set;
  logic         do_write, wr_lane0;
  logic [7:0]   wbyte;
  logic         wdata_strb0_r, wdata_strb0_nxt;
  logic         awready_r, wready_r, arready_r;
  // =========================================================
  // synchronisers and start-up timer
  svd_sync #(.WIDTH(2)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({analog_stat.tripped, analog_stat.ref_ready}),
    .sync_out (synced)
  ); // [RQ18]
  assign trip_s = synced[1];
  assign ref_s  = synced[0];
  svd_startup #(.CYCLES(STARTUP_CYCLES)) u_start (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (ctrl_r[POS_ENABLE]),
    .ref_ready (ref_s),
    .stable    (stable)
  );
  // comparator polarity is handled in the front end from the direction bit
  assign trip_edge = trip_s & ~trip_d_r;
  assign event_set = ctrl_r[POS_ENABLE] & ctrl_r[POS_REF_STABLE] & trip_edge; // [RQ3] [RQ8] [RQ9]
  // =========================================================
  // write path helpers
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction
  assign do_write = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_lane0 = do_write & wdata_strb0_r;
  assign wbyte    = wdata_r[7:0];
  // =========================================================
  // registers and detector logic
  always_comb begin
    ctrl_nxt  = ctrl_r;
    glob_nxt  = glob_r;
    flags_nxt = flags_r;
    ens_nxt   = ens_r;
    prio_nxt  = prio_r;
    sts_nxt   = sts_r;
    ien_nxt   = ien_r;
    if (wr_lane0) begin
      unique case (awaddr_r)
        ADDR_CONTROL:    ctrl_nxt  = merge(ctrl_r, wbyte, MASK_CONTROL_WR); // [RQ1] [RQ14]
        ADDR_GLOBAL:     glob_nxt  = merge(glob_r, wbyte, MASK_GLOBAL_WR);
        ADDR_FLAGS:      flags_nxt = merge(flags_r, wbyte, MASK_DET_BIT);
        ADDR_ENABLES:    ens_nxt   = merge(ens_r, wbyte, MASK_DET_BIT);
        ADDR_PRIORITIES: prio_nxt  = merge(prio_r, wbyte, MASK_DET_BIT);
        ADDR_IRQ_CLEAR:  sts_nxt   = sts_r & ~wbyte[0];
        ADDR_IRQ_ENABLE: ien_nxt   = wbyte[0];
        default: ;
      endcase
    end
    ctrl_nxt[POS_REF_STABLE] = stable; // [RQ17]
    if (event_set) begin
      flags_nxt[POS_DET_BIT] = 1'b1; // [RQ3] [RQ11]
      sts_nxt                = 1'b1;
    end
  end
  always_comb begin
    actl_nxt.comp_enable  = ctrl_r[POS_ENABLE];
    actl_nxt.use_external = (ctrl_r[3:0] == TRIP_EXTERNAL); // [RQ2]
    actl_nxt.tap_select   = ctrl_r[3:0]; // [RQ16]
    actl_nxt.direction    = ctrl_r[POS_DIRECTION]; // [RQ4] [RQ15]
    wake_nxt = core_sleeping & flags_r[POS_DET_BIT] & ens_r[POS_DET_BIT]; // [RQ11]
    vec_nxt  = flags_r[POS_DET_BIT] & ens_r[POS_DET_BIT] & glob_r[POS_GLOBAL_IRQ]; // [RQ12]
    irq_nxt  = sts_r & ien_r;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= RST_CONTROL; // [RQ13]
      glob_r   <= RST_GLOBAL;
      flags_r  <= RST_FLAGS;
      ens_r    <= RST_ENABLES;
      prio_r   <= RST_PRIOS;
      sts_r    <= 1'b0;
      ien_r    <= 1'b0;
      actl_r   <= '0;
      wake_r   <= 1'b0;
      vector_to_isr_r <= 1'b0;
      irq_r    <= 1'b0;
      trip_d_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      glob_r   <= glob_nxt;
      flags_r  <= flags_nxt;
      ens_r    <= ens_nxt;
      prio_r   <= prio_nxt;
      sts_r    <= sts_nxt;
      ien_r    <= ien_nxt;
      actl_r   <= actl_nxt;
      wake_r   <= wake_nxt;
      vector_to_isr_r <= vec_nxt;
      irq_r    <= irq_nxt;
      trip_d_r <= trip_s;
    end
  end
  assign analog_ctrl = actl_r;
  // =========================================================
  // axi4-lite slave
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CONTROL) || (a == ADDR_GLOBAL) || (a == ADDR_FLAGS) ||
              (a == ADDR_ENABLES) || (a == ADDR_PRIORITIES) || (a == ADDR_IRQ_STATUS) ||
              (a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE) || (a == ADDR_SLEEP);
  endfunction
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wdata_strb0_nxt = wdata_strb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (s_axi_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_got_r) begin
      w_got_nxt       = 1'b1;
      wdata_nxt       = s_axi_wdata;
      wdata_strb0_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ADDR_CONTROL:    rdata_nxt[7:0] = ctrl_r; // [RQ14] [RQ17]
        ADDR_GLOBAL:     rdata_nxt[7:0] = glob_r;
        ADDR_FLAGS:      rdata_nxt[7:0] = flags_r;
        ADDR_ENABLES:    rdata_nxt[7:0] = ens_r;
        ADDR_PRIORITIES: rdata_nxt[7:0] = prio_r;
        ADDR_IRQ_STATUS: rdata_nxt[0]   = sts_r;
        ADDR_IRQ_CLEAR:  rdata_nxt      = 32'h0000_0000;
        ADDR_IRQ_ENABLE: rdata_nxt[0]   = ien_r;
        ADDR_SLEEP:      rdata_nxt[0]   = core_sleeping;
        default:         rresp_nxt      = RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wdata_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wdata_strb0_r <= wdata_strb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
      awready_r <= ~aw_got_nxt;
      wready_r  <= ~w_got_nxt;
      arready_r <= ~rvalid_nxt;
    end
  end
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  // =========================================================
  // checks
  property p_no_flag_unstable;
    @(posedge aclk) disable iff (!aresetn)
      (!flags_r[POS_DET_BIT] && flags_nxt[POS_DET_BIT] && !wr_lane0) |-> ctrl_r[POS_REF_STABLE];
  endproperty
  a_no_flag_unstable: assert property (p_no_flag_unstable) else $error("flag set before reference stable"); // [RQ8]
  property p_ext_route;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (actl_r.use_external == ($past(ctrl_r[3:0]) == TRIP_EXTERNAL));
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("external route mismatch"); // [RQ2]
  property p_tap;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (actl_r.tap_select == $past(ctrl_r[3:0]));
  endproperty
  a_tap: assert property (p_tap) else $error("trip select not applied"); // [RQ1]
  property p_dir;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (actl_r.direction == $past(ctrl_r[POS_DIRECTION]));
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied"); // [RQ4]
  property p_event_flag;
    @(posedge aclk) disable iff (!aresetn) event_set |=> flags_r[POS_DET_BIT] && sts_r;
  endproperty
  a_event_flag: assert property (p_event_flag) else $error("trip did not set flag"); // [RQ3]
  property p_stable_drop;
    @(posedge aclk) disable iff (!aresetn) !ctrl_r[POS_ENABLE] |-> ##2 !ctrl_r[POS_REF_STABLE];
  endproperty
  a_stable_drop: assert property (p_stable_drop) else $error("stable while disabled"); // [RQ9]
  property p_unimpl;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_r[6] == 1'b0) && ((flags_r & ~MASK_DET_BIT) == 8'h00) && ((ens_r & ~MASK_DET_BIT) == 8'h00);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // [RQ14]
  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      (core_sleeping && flags_r[POS_DET_BIT] && ens_r[POS_DET_BIT]) |=> wake_r;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on trip in sleep"); // [RQ11]
  property p_vector;
    @(posedge aclk) disable iff (!aresetn) vector_to_isr_r |-> $past(glob_r[POS_GLOBAL_IRQ]);
  endproperty
  a_vector: assert property (p_vector) else $error("vector without global enable"); // [RQ12]
  property p_reset;
    @(posedge aclk) !aresetn |=> (ctrl_r == RST_CONTROL) && !actl_r.comp_enable;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not disable"); // [RQ13]
  property p_irq;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn) |-> (irq_r == $past(sts_r && ien_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output not following enabled status"); // [RQ8]
endmodule
`default_nettype wire

//--- dv/supply_threshold_detector_tb.sv
// self-checking bench for the supply threshold detector
`timescale 1ns/10ps
`default_nettype none
module supply_threshold_detector_tb;
  import svd_pkg::*;
  // =========================================================
  // signals
  logic         aclk;
  logic         aresetn;
  logic [7:0]   s_axi_awaddr;
  logic         s_axi_awvalid;
  logic         s_axi_awready;
  logic [31:0]  s_axi_wdata;
  logic [3:0]   s_axi_wstrb;
  logic         s_axi_wvalid;
  logic         s_axi_wready;
  logic [1:0]   s_axi_bresp;
  logic         s_axi_bvalid;
  logic         s_axi_bready;
  logic [7:0]   s_axi_araddr;
  logic         s_axi_arvalid;
  logic         s_axi_arready;
  logic [31:0]  s_axi_rdata;
  logic [1:0]   s_axi_rresp;
  logic         s_axi_rvalid;
  logic         s_axi_rready;
  analog_stat_t analog_stat;
  analog_ctrl_t analog_ctrl;
  logic         core_sleeping;
  logic         wake_r;
  logic         vector_to_isr_r;
  logic         irq_r;
  int           fails = 0;
  int           total_checks = 0;
  int           cyc = 0;
  logic [31:0]  rd;
  logic [1:0]   rsp;
  logic [3:0]   code;
  logic [7:0]   rst_tab [9] = '{RST_CONTROL, RST_GLOBAL, RST_FLAGS, RST_ENABLES, RST_PRIOS,
                                8'h00, 8'h00, 8'h00, 8'h00};
  // =========================================================
  // design under test, short start-up count
  supply_threshold_detector #(.STARTUP_CYCLES(40)) i_supply_threshold_detector (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_stat(analog_stat),
    .analog_ctrl(analog_ctrl), .core_sleeping(core_sleeping), .wake_r(wake_r),
    .vector_to_isr_r(vector_to_isr_r), .irq_r(irq_r)
  );
  // =========================================================
  // clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      close_out();
    end
  end
  // =========================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw || w);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    axi_rd(a);
    chk(rd, {24'h0, exp}, msg);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "read response");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(a, {24'h0, d}, 4'hF);
  endtask
  task automatic set_in(input logic t, input logic r);
    @(posedge aclk);
    analog_stat <= '{tripped: t, ref_ready: r};
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // =========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    analog_stat = '{tripped: 1'b0, ref_ready: 1'b0};
    core_sleeping = 1'b0;
    do_reset();
    for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), rst_tab[i], "reset value");
    chk(analog_ctrl.comp_enable, 1'b0, "enabled after reset");
    axi_rd(8'h24);
    chk(rd, 32'h0, "unmapped data");
    chk(rsp, RESP_SLVERR, "unmapped read response");
    wr(8'h24, 8'hFF);
    chk(rsp, RESP_SLVERR, "unmapped write response");
    for (int c = 0; c < 16; c++) begin
      code = 4'(c);
      wr(ADDR_CONTROL, {code[0], 3'h0, code});
      cycles(2);
      chk(analog_ctrl.tap_select, code, "tap select");
      chk(analog_ctrl.use_external, code == TRIP_EXTERNAL, "external input");
      chk(analog_ctrl.direction, code[0], "direction");
      rd_chk(ADDR_CONTROL, {code[0], 3'h0, code}, "control readback");
    end
    axi_wr(ADDR_CONTROL, 32'h10, 4'hE);
    rd_chk(ADDR_CONTROL, 8'h8F, "masked byte lane");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h0E);
    wr(ADDR_CONTROL, 8'h8E);
    wr(ADDR_CONTROL, 8'hBE);
    set_in(1'b1, 1'b0);
    cycles(60);
    chk(analog_ctrl.comp_enable, 1'b1, "enable");
    rd_chk(ADDR_CONTROL, 8'h9E, "stable without reference");
    rd_chk(ADDR_FLAGS, 8'h00, "flag before stable");
    set_in(1'b0, 1'b1);
    cycles(60);
    rd_chk(ADDR_CONTROL, 8'hBE, "stable set");
    set_in(1'b1, 1'b1);
    cycles(10);
    rd_chk(ADDR_FLAGS, 8'h04, "flag on trip");
    wr(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00, "flag cleared");
    wr(ADDR_CONTROL, 8'h8E);
    set_in(1'b0, 1'b1);
    wr(ADDR_CONTROL, 8'h9E);
    set_in(1'b1, 1'b1);
    cycles(10);
    rd_chk(ADDR_CONTROL, 8'h9E, "stable during start-up");
    cycles(40);
    rd_chk(ADDR_CONTROL, 8'hBE, "stable after start-up");
    rd_chk(ADDR_FLAGS, 8'h00, "trip in start-up missed");
    set_in(1'b0, 1'b1);
    cycles(8);
    set_in(1'b1, 1'b1);
    cycles(10);
    rd_chk(ADDR_FLAGS, 8'h04, "flag after start-up");
    rd_chk(ADDR_IRQ_STATUS, 8'h01, "irq status");
    wr(ADDR_IRQ_ENABLE, 8'h01);
    cycles(3);
    chk(irq_r, 1'b1, "irq raised");
    wr(ADDR_IRQ_ENABLE, 8'h00);
    cycles(3);
    chk(irq_r, 1'b0, "irq masked");
    wr(ADDR_IRQ_ENABLE, 8'h01);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    cycles(3);
    chk(irq_r, 1'b0, "irq cleared");
    rd_chk(ADDR_IRQ_STATUS, 8'h00, "status cleared");
    rd_chk(ADDR_IRQ_CLEAR, 8'h00, "clear reads zero");
    wr(ADDR_ENABLES, 8'hFF);
    rd_chk(ADDR_ENABLES, 8'h04, "enables mask");
    wr(ADDR_PRIORITIES, 8'hFB);
    rd_chk(ADDR_PRIORITIES, 8'h00, "priorities mask");
    cycles(3);
    chk(vector_to_isr_r, 1'b0, "no vector without global");
    chk(wake_r, 1'b0, "no wake when awake");
    @(posedge aclk);
    core_sleeping <= 1'b1;
    cycles(3);
    chk(wake_r, 1'b1, "wake in sleep");
    wr(ADDR_GLOBAL, 8'hFF);
    rd_chk(ADDR_GLOBAL, 8'hC0, "global mask");
    cycles(3);
    chk(vector_to_isr_r, 1'b1, "vector with global");
    wr(ADDR_FLAGS, 8'h00);
    cycles(3);
    chk(wake_r, 1'b0, "wake drops on clear");
    set_in(1'b0, 1'b1);
    cycles(8);
    set_in(1'b1, 1'b1);
    cycles(10);
    chk(wake_r, 1'b1, "trip in sleep wakes");
    wr(ADDR_CONTROL, 8'h0E);
    cycles(2);
    chk(analog_ctrl.comp_enable, 1'b0, "disabled after check");
    do_reset();
    cycles(2);
    chk(analog_ctrl.comp_enable, 1'b0, "enabled after reset");
    chk(irq_r | wake_r | vector_to_isr_r, 1'b0, "outputs after reset");
    rd_chk(ADDR_CONTROL, RST_CONTROL, "control after reset");
    rd_chk(ADDR_FLAGS, RST_FLAGS, "flags after reset");
    close_out();
  end
endmodule
`default_nettype wire
